// ### core/frame_shifter.sv
`timescale 1ns/1ps
module frame_shifter (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  // pins after the synchroniser
  input  wire spi_diag_pkg::pins_t          pins,
  // reply word, taken when the frame opens
  input  wire logic [spi_diag_pkg::FRAME_W-1:0] tx_word,
  // serial output
  output logic                              so_r,
  output logic                              so_oe_r,
  // frame results
  output logic                              frame_start,
  output logic                              frame_done_r,
  output logic                              frame_ok_r,
  output logic [spi_diag_pkg::FRAME_W-1:0]  rx_r
);
  import spi_diag_pkg::*;

  logic               sclk_d_r;
  logic               csn_d_r;
  logic [FRAME_W-1:0] tx_sh_r;
  logic [2:0]         bit_mod_r;
  logic [1:0]         octet_r;
  logic               fall;
  logic               stop;

  // ------------------------------------------------------------
  // edge detection, clock activity ignored while deselected
  // ------------------------------------------------------------
  assign fall        = sclk_d_r & ~pins.sclk & ~pins.chip_select_n;  // RULE21
  assign frame_start = csn_d_r & ~pins.chip_select_n;
  assign stop        = ~csn_d_r & pins.chip_select_n;

  // previous pin levels
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sclk_d_r <= 1'h0;
      csn_d_r  <= 1'h1;
    end else begin
      sclk_d_r <= pins.sclk;
      csn_d_r  <= pins.chip_select_n;
    end
  end

  // ------------------------------------------------------------
  // shift path: sample on falling sclk, next bit out right after
  // ------------------------------------------------------------
  // incoming bits refill the tail, so longer frames pass through
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_sh_r <= '0;
      rx_r    <= '0;
      so_r    <= 1'h0;
    end else if (frame_start) begin
      so_r    <= tx_word[FRAME_W-1];                      // RULE1
      tx_sh_r <= {tx_word[FRAME_W-2:0], 1'h0};
    end else if (fall) begin
      so_r    <= tx_sh_r[FRAME_W-1];                      // RULE20
      tx_sh_r <= {tx_sh_r[FRAME_W-2:0], pins.si};
      rx_r    <= {rx_r[FRAME_W-2:0], pins.si};            // RULE20
    end
  end

  // output driven only while selected
  always_ff @(posedge ref_clk) begin
    if (sys_rst) so_oe_r <= 1'h0;
    else         so_oe_r <= ~pins.chip_select_n;          // RULE21
  end

  // ------------------------------------------------------------
  // length check: multiple of 8 and at least 16 clocks
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst || frame_start) begin
      bit_mod_r <= BIT_MOD_ZERO;
      octet_r   <= '0;
    end else if (fall) begin
      bit_mod_r <= bit_mod_r + 3'h1;
      if (bit_mod_r == BIT_MOD_LAST && octet_r != MIN_OCTETS)
        octet_r <= octet_r + 2'h1;
    end
  end

  // end-of-frame pulse with its verdict
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      frame_done_r <= 1'h0;
      frame_ok_r   <= 1'h0;
    end else begin
      frame_done_r <= stop;
      frame_ok_r   <= stop && bit_mod_r == BIT_MOD_ZERO
                      && octet_r == MIN_OCTETS;           // RULE2
    end
  end

endmodule : frame_shifter

// ### core/spi_diag_pkg.sv
package spi_diag_pkg;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int FRAME_W     = 16;
  localparam int ADDR_W      = 6;
  localparam int DATA_W      = 8;
  localparam int RDATA_W     = 15;
  localparam int BIT_RW      = 15;
  localparam int BIT_BANK    = 14;
  localparam int ADDR_HI     = 13;
  localparam int ADDR_LO     = 8;
  localparam int BIT_DIAG_RD = 0;

  // transfer length check: bits modulo 8, whole bytes seen
  localparam logic [2:0] BIT_MOD_LAST = 3'h7;
  localparam logic [2:0] BIT_MOD_ZERO = 3'h0;
  localparam logic [1:0] MIN_OCTETS   = 2'h2;

  // command words decoded by this block (bank 0 writes)
  localparam logic [ADDR_W-1:0] CLR_LATCH_ADDR   = 6'h3f;
  localparam logic [ADDR_W-1:0] ROUTINE_SEL_ADDR = 6'h3e;
  localparam logic              CMD_BANK         = 1'h0;

  // routine selector write: data[2:1] routine, data[0] channel
  localparam int         N_RT      = 3;
  localparam int         RT_IDX_HI = 2;
  localparam int         RT_IDX_LO = 1;
  localparam int         RT_CH_BIT = 0;
  localparam logic [1:0] RT_LAST   = 2'h2;
  localparam logic       DIAG_MSB  = 1'h0;
  localparam logic       REG_MSB   = 1'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RSVD = 2'h0, ST_LIMP = 2'h1, ST_ACTIVE = 2'h2, ST_IDLE = 2'h3
  } op_state_t;

  typedef enum logic [1:0] {RPL_DIAG = 2'h1, RPL_REG = 2'h2} reply_kind_t;

  typedef struct packed {
    logic chip_select_n;
    logic sclk;
    logic si;
  } pins_t;

  typedef struct packed {
    logic shorted_load;
    logic open_load;
    logic output_overvoltage;
  } chan_t;

  // done vectors are {monitor, fast shutdown, calibration}
  typedef struct packed {
    op_state_t         state;
    logic              overtemp_warning;
    logic [N_RT-1:0]   done_ch1;
    logic [N_RT-1:0]   done_ch2;
    chan_t             ch1;
    chan_t             ch2;
  } live_t;

  typedef struct packed {
    logic soft_reset;
    logic logic_undervoltage;
    logic enable_input_lockout;
    logic supply_low_ch2;
    logic supply_low_ch1;
    logic internal_lockout;
    logic overtemp;
  } event_t;

  typedef struct packed {
    logic soft_reset_seen;
    logic undervoltage_reset_seen;
    logic transfer_error;
    logic driver_supply_low_ch2;
    logic driver_supply_low_ch1;
    logic internal_supply_lockout;
    logic overtemp_shutdown;
  } latch_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic              bank_select;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  localparam pins_t    PINS_IDLE  = '{chip_select_n: 1'h1, default: 1'h0};
  localparam latch_t   LATCH_INIT = '{undervoltage_reset_seen: 1'h1, default: 1'h0};
  localparam latch_t   AUTO_CLR   = '{overtemp_shutdown: 1'h0, default: 1'h1};
  localparam latch_t   LATCH_NONE = '0;
  localparam reg_req_t REQ_IDLE   = '0;

endpackage : spi_diag_pkg

// ### core/spi_frame_and_diag_responder.sv
// Behaviour
// (RULE1) reply to a command comes next transfer
// (RULE2) valid frame: clocks multiple of 8, >=16
// (RULE3) after bad frame, reply ignores its content
// (RULE4) first reply after undervoltage ignores history
// (RULE5) unknown register address answered with diagnosis
// (RULE6) bit15 write, bit14 bank, bit0 diagnosis
// (RULE7) register read spans two transfers
// (RULE8) register reply MSB high, diagnosis MSB low
// (RULE9) new command executes during read reply
// (RULE10) diagnosis readout clears the latched flags
// (RULE11) overtemperature flag cleared only by clear command
// (RULE12) state and warning bits are live
// (RULE13) routine-done and fault bits mirror inputs
// (RULE14) clear command resets latches, restarts switching
// (RULE15) quiet active device reads 1000 hex
// (RULE16) fixed diagnosis word bit layout
// (RULE17) state codes: limp, active, idle
// (RULE18) channel fault is OR of three flags
// (RULE19) done mirrors follow last selected channel
// (RULE20) sample falling edge, output shifted before it
// (RULE21) deselected: output released, clock ignored
// (RULE22) error or undervoltage reply is diagnosis word
`timescale 1ns/1ps
module spi_frame_and_diag_responder (
  // clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              sys_rst,
  // serial pins
  input  wire logic                              chip_select_n,
  input  wire logic                              sclk,
  input  wire logic                              si,
  output logic                                   so_r,
  output logic                                   so_oe_r,
  // live status and fault events
  input  wire spi_diag_pkg::live_t               live,
  input  wire spi_diag_pkg::event_t              events,
  // register bank side
  output spi_diag_pkg::reg_req_t                 reg_req_r,
  input  wire logic                              reg_known,
  input  wire logic [spi_diag_pkg::RDATA_W-1:0]  reg_rdata,
  // protection restart and latch view
  output logic                                   clear_latches_r,
  output spi_diag_pkg::latch_t                   latch_r
);
  import spi_diag_pkg::*;

  pins_t              pins_m_r;
  pins_t              pins_s_r;
  logic               frame_start;
  logic               frame_done_r;
  logic               frame_ok_r;
  logic [FRAME_W-1:0] rx_r;
  logic [FRAME_W-1:0] tx_word;
  logic [FRAME_W-1:0] diag_now;
  reply_kind_t        reply_kind_r;
  logic               tx_diag_r;
  latch_t             shown_r;
  latch_t             latch_nxt;
  latch_t             set_v;
  latch_t             clr_v;
  logic [N_RT-1:0]    rt_sel_r;
  logic               uv_d_r;
  logic               uv_exit;
  logic               is_wr;
  logic               is_diag_rd;
  logic               is_reg_rd;
  logic               cmd_ok;
  logic               cmd_clr;
  logic               cmd_rt;
  logic [ADDR_W-1:0]  rx_addr;
  logic [DATA_W-1:0]  rx_data;
  logic [1:0]         rt_idx;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // per-channel fault summary
  function automatic logic chan_fault(input chan_t c);
    chan_fault = c.shorted_load | c.open_load | c.output_overvoltage;  // RULE18
  endfunction : chan_fault

  // assemble the diagnosis word from latches and live inputs
  function automatic logic [FRAME_W-1:0] diag_word(
    input latch_t          l,
    input live_t           v,
    input logic [N_RT-1:0] sel
  );
    logic [N_RT-1:0] done;
    done = (sel & v.done_ch2) | (~sel & v.done_ch1);  // RULE19
    diag_word = {DIAG_MSB,                            // RULE16
                 l.soft_reset_seen,
                 l.undervoltage_reset_seen,
                 v.state,                             // RULE17
                 l.transfer_error,
                 done,                                // RULE13
                 l.driver_supply_low_ch2,
                 l.driver_supply_low_ch1,
                 l.internal_supply_lockout,
                 chan_fault(v.ch2),                   // RULE13
                 chan_fault(v.ch1),
                 l.overtemp_shutdown,
                 v.overtemp_warning};                 // RULE12
  endfunction : diag_word

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // the first stage is read by the second stage only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pins_m_r <= PINS_IDLE;
      pins_s_r <= PINS_IDLE;
    end else begin
      pins_m_r <= '{chip_select_n: chip_select_n, sclk: sclk, si: si};
      pins_s_r <= pins_m_r;
    end
  end

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  frame_shifter u_shift (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .pins         (pins_s_r),
    .tx_word      (tx_word),
    .so_r         (so_r),
    .so_oe_r      (so_oe_r),
    .frame_start  (frame_start),
    .frame_done_r (frame_done_r),
    .frame_ok_r   (frame_ok_r),
    .rx_r         (rx_r)
  );

  // ----------------------------------------------------------------
  // reply selection
  // ----------------------------------------------------------------
  // diagnosis is built live when the frame opens, never stored early
  assign diag_now = diag_word(latch_r, live, rt_sel_r);  // RULE12

  // unknown address falls back to the diagnosis word
  always_comb begin
    if (reply_kind_r == RPL_REG && reg_known)
      tx_word = {REG_MSB, reg_rdata};                   // RULE8
    else
      tx_word = diag_now;                               // RULE5
  end

  // what the open frame carries, and which latches it showed
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_diag_r <= 1'h1;
      shown_r   <= LATCH_NONE;
    end else if (frame_start) begin
      tx_diag_r <= tx_word[FRAME_W-1] == DIAG_MSB;
      shown_r   <= latch_r;
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign rx_addr    = rx_r[ADDR_HI:ADDR_LO];
  assign rx_data    = rx_r[DATA_W-1:0];
  assign rt_idx     = rx_data[RT_IDX_HI:RT_IDX_LO];
  assign is_wr      = rx_r[BIT_RW];                        // RULE6
  assign is_diag_rd = ~rx_r[BIT_RW] & rx_r[BIT_DIAG_RD];   // RULE6
  assign is_reg_rd  = ~rx_r[BIT_RW] & ~rx_r[BIT_DIAG_RD];  // RULE6
  // a bad frame executes nothing
  assign cmd_ok     = frame_done_r & frame_ok_r;          // RULE3
  assign cmd_clr    = cmd_ok & is_wr & rx_r[BIT_BANK] == CMD_BANK
                      & rx_addr == CLR_LATCH_ADDR;
  assign cmd_rt     = cmd_ok & is_wr & rx_r[BIT_BANK] == CMD_BANK
                      & rx_addr == ROUTINE_SEL_ADDR;

  // reply kind for the next transfer
  always_ff @(posedge ref_clk) begin
    if (sys_rst || uv_exit)
      reply_kind_r <= RPL_DIAG;                          // RULE4
    else if (frame_done_r) begin
      case (reply_kind_r)
        RPL_DIAG, RPL_REG: begin
          if (cmd_ok && is_reg_rd)
            reply_kind_r <= RPL_REG;                     // RULE7
          else
            reply_kind_r <= RPL_DIAG;                    // RULE22
        end
        default: reply_kind_r <= RPL_DIAG;
      endcase
    end
  end

  // register access strobes, fields held until the next write or register read
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      reg_req_r <= REQ_IDLE;
    else begin
      reg_req_r.wr <= cmd_ok & is_wr;                    // RULE9
      reg_req_r.rd <= cmd_ok & is_reg_rd;                // RULE9
      if (cmd_ok && !is_diag_rd) begin
        reg_req_r.bank_select <= rx_r[BIT_BANK];
        reg_req_r.addr        <= rx_addr;
        reg_req_r.wdata       <= rx_data;
      end
    end
  end

  // routine channel selectors, channel 1 after reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      rt_sel_r <= '0;
    else if (cmd_rt && rt_idx <= RT_LAST)
      rt_sel_r[rt_idx] <= rx_data[RT_CH_BIT];            // RULE19
  end

  // restart pulse toward the protection logic
  always_ff @(posedge ref_clk) begin
    if (sys_rst) clear_latches_r <= 1'h0;
    else         clear_latches_r <= cmd_clr;             // RULE14
  end

  // ----------------------------------------------------------------
  // latched flags
  // ----------------------------------------------------------------
  // leaving undervoltage (both conditions released) forces a diagnosis reply and sets the undervoltage flag
  always_ff @(posedge ref_clk) begin
    if (sys_rst) uv_d_r <= 1'h0;
    else uv_d_r <= events.logic_undervoltage | events.enable_input_lockout;
  end
  assign uv_exit = uv_d_r & ~events.logic_undervoltage
                   & ~events.enable_input_lockout;

  // sources that set a flag
  always_comb begin
    set_v                         = LATCH_NONE;
    set_v.soft_reset_seen         = events.soft_reset;
    set_v.undervoltage_reset_seen = uv_exit;                       // RULE22
    set_v.transfer_error          = frame_done_r & ~frame_ok_r;    // RULE22
    set_v.driver_supply_low_ch2   = events.supply_low_ch2;
    set_v.driver_supply_low_ch1   = events.supply_low_ch1;
    set_v.internal_supply_lockout = events.internal_lockout;
    set_v.overtemp_shutdown       = events.overtemp;
  end

  // only flags that were really shown get cleared by the readout
  always_comb begin
    clr_v = LATCH_NONE;
    if (cmd_ok && tx_diag_r)
      clr_v = shown_r & AUTO_CLR;                        // RULE10 RULE11
    if (cmd_clr)
      clr_v = ~LATCH_NONE;                               // RULE14
  end

  // a set in the clearing cycle wins so no event is lost
  assign latch_nxt = (latch_r & ~clr_v) | set_v;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) latch_r <= LATCH_INIT;                  // RULE4
    else         latch_r <= latch_nxt;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // a bad frame flags the error and forces the diagnosis reply
  chk_error_reply: assert property ( // RULE3
    frame_done_r && !frame_ok_r
    |=> reply_kind_r == RPL_DIAG && latch_r.transfer_error)
    else $error("bad frame did not force diagnosis reply");

  // first cycle out of reset has a diagnosis reply and the flag
  chk_reset_reply: assert property ( // RULE4
    $past(sys_rst)
    |-> reply_kind_r == RPL_DIAG && latch_r.undervoltage_reset_seen)
    else $error("reply after reset not diagnosis");

  // the word loaded into the shifter has the right msb
  chk_reply_msb: assert property ( // RULE8
    frame_start
    |=> so_r == (reply_kind_r == RPL_REG && reg_known))
    else $error("reply msb does not match reply kind");

  // a valid register read turns into a register reply and a strobe
  chk_read_exec: assert property ( // RULE7
    cmd_ok && is_reg_rd
    |=> reply_kind_r == RPL_REG && reg_req_r.rd)
    else $error("register read not executed");

  // readout with no new soft reset clears the shown soft reset flag
  chk_diag_clear: assert property ( // RULE10
    cmd_ok && tx_diag_r && shown_r.soft_reset_seen
    && !events.soft_reset && !cmd_clr
    |=> !latch_r.soft_reset_seen)
    else $error("soft reset flag survived readout");

  // overtemperature survives a plain readout
  chk_tsd_hold: assert property ( // RULE11
    latch_r.overtemp_shutdown && !cmd_clr
    |=> latch_r.overtemp_shutdown)
    else $error("overtemperature flag lost without clear");

  // clear command pulses the restart and drops overtemperature
  chk_clr_latch: assert property ( // RULE14
    cmd_clr && !events.overtemp
    |=> clear_latches_r && !latch_r.overtemp_shutdown
    ##1 !clear_latches_r)
    else $error("clear command did not reset latches");

  // deselected two cycles means the output is released
  chk_cs_idle: assert property ( // RULE21
    pins_s_r.chip_select_n [*2] |-> !so_oe_r)
    else $error("serial output driven while deselected");

  // quiet active device shows the nominal word
  chk_quiet_word: assert property ( // RULE15
    latch_r == LATCH_NONE && live.state == ST_ACTIVE
    && !live.overtemp_warning && live.done_ch1 == '0
    && live.done_ch2 == '0 && live.ch1 == '0 && live.ch2 == '0
    |-> diag_now == {DIAG_MSB, LATCH_NONE[1:0], ST_ACTIVE,
                     {(FRAME_W-5){1'h0}}})
    else $error("quiet diagnosis word wrong");

  // leaving undervoltage drops a pending register reply
  chk_uv_reply: assert property ( // RULE4
    uv_exit
    |=> reply_kind_r == RPL_DIAG && latch_r.undervoltage_reset_seen)
    else $error("undervoltage exit did not force diagnosis reply");

  // a write in any valid frame reaches the register side with its address and data
  chk_write_exec: assert property ( // RULE9
    cmd_ok && is_wr
    |=> reg_req_r.wr && reg_req_r.addr == $past(rx_addr)
        && reg_req_r.wdata == $past(rx_data))
    else $error("write command not forwarded");

  // the restart pulse comes from the clear command only
  chk_clr_only: assert property ( // RULE14
    !cmd_clr |=> !clear_latches_r)
    else $error("restart pulse without clear command");

  cov_bad_frame:  cover property (frame_done_r && !frame_ok_r);
  cov_reg_read:   cover property (frame_start && reply_kind_r == RPL_REG);
  cov_diag_clear: cover property (cmd_ok && tx_diag_r && shown_r != LATCH_NONE);
  cov_clear_cmd:  cover property (cmd_clr);

endmodule : spi_frame_and_diag_responder

// ### verification/spi_frame_and_diag_responder_tb.sv
`timescale 1ns/1ps
module spi_frame_and_diag_responder_tb;
  import spi_diag_pkg::*;
  typedef struct packed {
    logic [15:0] cmd;
    logic [5:0]  nbits;
    live_t       live;
    logic [15:0] exp;
  } row_t;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic chip_select_n, sclk, si, so_r, so_oe_r, clear_latches, reg_known;
  wire  so_pin;
  live_t live = live_t'(15'h4000);
  event_t events = '0;
  reg_req_t reg_req;
  latch_t latch;
  logic [14:0] reg_rdata;
  logic [15:0] rx;
  int mismatches = 0;
  int n_checks = 0;
  int n_clr = 0;
  // command, bits, live status, expected reply of that frame
  row_t rows [11] = '{
    {16'h0001, 6'd16, 15'h4000, 16'h3000}, {16'h0500, 6'd16, 15'h4000, 16'h1000},
    {16'h6000, 6'd16, 15'h4000, 16'h855a}, {16'h0001, 6'd16, 15'h6000, 16'h1800},
    {16'h8312, 6'd16, 15'h2000, 16'h0800}, {16'hbe01, 6'd16, 15'h5000, 16'h1001},
    {16'h0001, 6'd24, 15'h4041, 16'h1088}, {16'h0001, 6'd16, 15'h4811, 16'h120c},
    {16'h0001, 6'd17, 15'h4000, 16'h1000}, {16'h0001, 6'd16, 15'h4000, 16'h1400},
    {16'h0001, 6'd16, 15'h4000, 16'h1000}};

  always #4 ref_clk = ~ref_clk;
  // released output floats, so a stray sample never matches
  assign so_pin    = so_oe_r ? so_r : 1'bz;
  // address 20 hex stands for an unused register
  assign reg_known = reg_req.addr !== 6'h20;
  assign reg_rdata = {reg_req.bank_select, reg_req.addr, 8'h5a};
  always @(negedge ref_clk) if (clear_latches === 1'h1) n_clr++;

  spi_frame_and_diag_responder u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
    .sclk(sclk), .si(si), .so_r(so_r), .so_oe_r(so_oe_r), .live(live),
    .events(events), .reg_req_r(reg_req), .reg_known(reg_known),
    .reg_rdata(reg_rdata), .clear_latches_r(clear_latches), .latch_r(latch));
  spi_host_model u_host (
    .ref_clk(ref_clk), .chip_select_n(chip_select_n), .sclk(sclk), .si(si),
    .so_pin(so_pin));

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 1'h0;
    check("latch reset", {9'h0, latch}, {9'h0, LATCH_INIT});
    foreach (rows[i]) begin
      live = rows[i].live;
      u_host.xfer({16'h0, rows[i].cmd}, rows[i].nbits, rx);
      check("reply", rx, rows[i].exp);
    end
    // overtemperature survives diagnosis reads until a clear
    events.overtemp   = 1'h1;
    events.soft_reset = 1'h1;
    @(negedge ref_clk) events = '0;
    u_host.xfer(32'h1, 16, rx);
    check("tsd first", rx, 16'h5002);
    u_host.xfer(32'hbf00, 16, rx);
    check("tsd second", rx, 16'h1002);
    check("clear pulse", 16'(n_clr), 16'h1);
    check("tsd latch", {15'h0, latch.overtemp_shutdown}, 16'h0);
    u_host.xfer(32'h1, 16, rx);
    check("after clear", rx, 16'h1000);
    // a pending register reply gives way to an undervoltage exit
    u_host.xfer(32'h0500, 16, rx);
    check("before lockout", rx, 16'h1000);
    events.enable_input_lockout = 1'h1;
    @(negedge ref_clk) events.enable_input_lockout = 1'h0;
    u_host.xfer(32'h1, 16, rx);
    check("after lockout", rx, 16'h3000);
    // clock noise while deselected, then a reset mid-run
    u_host.noise(7);
    check("released", {15'h0, so_oe_r}, 16'h0);
    u_host.xfer(32'h1, 16, rx);
    check("after noise", rx, 16'h1000);
    sys_rst = 1'h1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'h0;
    check("latch again", {9'h0, latch}, {9'h0, LATCH_INIT});
    repeat (3) @(negedge ref_clk);
    u_host.xfer(32'h1, 16, rx);
    check("after reset", rx, 16'h3000);
    final_report();
  end

  // a hang ends the run through the same report
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
endmodule : spi_frame_and_diag_responder_tb

// ### verification/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // pacing clock
  input  wire logic ref_clk,
  // serial pins
  output logic      chip_select_n,
  output logic      sclk,
  output logic      si,
  input  wire logic so_pin
);
  // ----------------------------------------------------------------
  // idle pins: select pulled up, clock and data pulled down
  // ----------------------------------------------------------------
  initial begin
    chip_select_n = 1'h1;
    sclk          = 1'h0;
    si            = 1'h0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_clk

  // clock edges while deselected must leave the device untouched
  task automatic noise(input int n);
    repeat (n) begin
      sclk = ~sclk;
      wait_clk(5);
    end
    sclk = 1'h0;
  endtask : noise

  // five cycles a phase give the 80 ns link clock of the bench
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0;
    chip_select_n = 1'h0;
    wait_clk(25);
    for (int i = nbits - 1; i >= 0; i--) begin
      si = tx[i];
      sclk = 1'h1;
      wait_clk(5);
      if (i >= nbits - 16) rx = {rx[14:0], so_pin};
      sclk = 1'h0;
      wait_clk(5);
    end
    wait_clk(25);
    chip_select_n = 1'h1;
    si = 1'h0;
    wait_clk(40);
  endtask : xfer
endmodule : spi_host_model
